// ---- rtl/port_mux_defs.svh ----
// Purpose: Offsets, field positions and reset values of the port pin mux.
// Assumes: 32-bit APB data, one register per aligned word.
// Notes:   Definitions only.
`ifndef PORT_MUX_DEFS_SVH
`define PORT_MUX_DEFS_SVH

// Register byte offsets: one group of four registers per port.
`define OFS_P3_SEL 12'h000
`define OFS_P3_DIR 12'h004
`define OFS_P3_OUT 12'h008
`define OFS_P3_IN  12'h00C
`define PORT_STRIDE 12'h010
`define PORT_COUNT 4

// Port index decode: address bits 5:4 pick the port, bits 3:2 the register.
`define REG_SEL 2'h0
`define REG_DIR 2'h1
`define REG_OUT 2'h2
`define REG_IN  2'h3

// Serial control register.
`define OFS_SERIAL_CTL 12'h040
`define SERIAL_CTL_SYNC_BIT 0
`define SERIAL_CTL_MASTER_BIT 1

// Pin-level status register.
`define OFS_STATUS 12'h044
`define STATUS_HIZ_BIT 0

// Reset values.
`define RST_PORT 8'h00
`define RST_SERIAL_CTL 2'h0

`endif

// ---- rtl/port_mux_pkg.sv ----
// Purpose: Types shared by the port pin mux.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in port_mux_defs.svh.
package port_mux_pkg;

	// Software state of one 8-bit port.
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] dir;
		logic [7:0] out;
	} port_ctl_t;

	// Two-signal pin bundle for one port.
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} pin_drive_t;

	// Signals coming from the on-chip modules.
	typedef struct packed {
		logic       serial_txd;
		logic       serial_clk_out;
		logic [2:0] timer_cmp;
		logic       main_clk;
		logic       sub_main_clock;
		logic       aux_clk;
	} module_out_t;

	// Signals handed to the on-chip modules.
	typedef struct packed {
		logic       serial_slave_transmit_enable;
		logic       serial_async_receive_data;
		logic       serial_clk_in;
		logic [2:0] timer_cap_a;
		logic [2:0] timer_cap_b;
		logic       timer_output_high_impedance_ctl;
	} module_in_t;

	// Serial unit mode as held in software.
	typedef struct packed {
		logic master;
		logic sync;
	} serial_mode_t;

endpackage

// ---- rtl/port_pin_function_mux.sv ----
// Purpose: Function multiplexer for ports 3 to 6 with an APB register slave.
// Assumes: One clock pclk at 100 MHz; pins sampled synchronously.
// Notes:   Pin routing is combinational; pin data outputs are combinational
//          paths from module signals by nature of a mux.
//
// Summary of operation
// - Port 3 bit 0 module: input, low out, level to slave enable.
// - Port 3 bit 4 module: output driven by async transmit data.
// - Port 3 bit 5 module: input, low out, level to receive data.
// - Port 3 bit 6 module: output low; bit 7 module: input, unused.
// - Async mode with bit 3 assigned: clock pin is strictly an input.
// - Sync slave: external master clocks the pin; device shifts on it.
// - Sync master: device drives the shift clock on port 3 bit 3.
// - Port 4 bits 0-2 module: timer compare out, capture A and B in.
// - Port 4 module function keeps the pin's own direction bit.
// - Port 4 bits 3-6 module: constant low output, input unused.
// - High-impedance control floats port 4 pins 0 to 6.
// - Port 5 bits 4-6 module: output main, sub-main, auxiliary clocks.
// - Port 5 bit 7 module: input driving the high-impedance control.
// - Port 5 bits 1-3 module: output low; bit 0 input, unused.
// - Port 6 module function keeps own direction, drives low.
// - Port 6 direction 0 enables input function, else input is parked.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "port_mux_defs.svh"

module port_pin_function_mux (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic                           pready,
	output logic                           pslverr,
	output logic [31:0]                    prdata,
	input  wire logic [31:0]               pin_in,
	output port_mux_pkg::pin_drive_t [3:0] pin_drive,
	input  wire port_mux_pkg::module_out_t mod_out,
	output port_mux_pkg::module_in_t       mod_in
);
	import port_mux_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	port_ctl_t    ctl [`PORT_COUNT];
	port_ctl_t    next_ctl [`PORT_COUNT];
	serial_mode_t mode;
	serial_mode_t next_mode;
	logic [31:0]  rdata;
	logic [31:0]  next_rdata;
	logic         hiz_ctl;

	// Checks whether an address falls into the port register window.
	function automatic logic in_port_window(input logic [11:0] a);
		in_port_window = (a[11:6] == 6'h00) && (a[1:0] == 2'h0);
	endfunction

	logic access;
	logic wr_hit;
	logic mapped;

	// Writes and reads complete in the access cycle; no wait states.
	assign access  = psel && penable;
	assign wr_hit  = access && pwrite;
	assign pready  = 1'b1;
	assign mapped  = in_port_window(paddr) ||
		(paddr == `OFS_SERIAL_CTL) || (paddr == `OFS_STATUS);
	assign pslverr = access && !mapped;
	assign prdata  = rdata;

	// Next register values; a write lands only in the access phase.
	always_comb begin
		for (int p = 0; p < `PORT_COUNT; p++) begin
			next_ctl[p] = ctl[p];
			if (wr_hit && in_port_window(paddr) &&
				(paddr[5:4] == 2'(p))) begin
				case (paddr[3:2])
					`REG_SEL: next_ctl[p].sel = pwdata[7:0];
					`REG_DIR: next_ctl[p].dir = pwdata[7:0];
					`REG_OUT: next_ctl[p].out = pwdata[7:0];
					default:  next_ctl[p].out = ctl[p].out;
				endcase
			end
		end
		next_mode = mode;
		if (wr_hit && (paddr == `OFS_SERIAL_CTL)) begin
			next_mode.sync   = pwdata[`SERIAL_CTL_SYNC_BIT];
			next_mode.master = pwdata[`SERIAL_CTL_MASTER_BIT];
		end
	end

	// Read data is captured at the setup cycle so it is ready in access.
	always_comb begin
		next_rdata = rdata;
		if (psel && !penable && !pwrite) begin
			next_rdata = 32'h0000_0000;
			if (in_port_window(paddr)) begin
				case (paddr[3:2])
					`REG_SEL: next_rdata[7:0] = ctl[paddr[5:4]].sel;
					`REG_DIR: next_rdata[7:0] = ctl[paddr[5:4]].dir;
					`REG_OUT: next_rdata[7:0] = ctl[paddr[5:4]].out;
					default:  next_rdata[7:0] = pin_in[paddr[5:4]*8 +: 8];
				endcase
			end else if (paddr == `OFS_SERIAL_CTL) begin
				next_rdata[1:0] = {mode.master, mode.sync};
			end else if (paddr == `OFS_STATUS) begin
				next_rdata[`STATUS_HIZ_BIT] = hiz_ctl;
			end
		end
	end

	// Plain registering of the bus-facing state; reset makes pins inputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < `PORT_COUNT; p++) begin
				ctl[p] <= '{`RST_PORT, `RST_PORT, `RST_PORT};
			end
			mode  <= `RST_SERIAL_CTL;
			rdata <= 32'h0000_0000;
		end else begin
			for (int p = 0; p < `PORT_COUNT; p++) begin
				ctl[p] <= next_ctl[p];
			end
			mode  <= next_mode;
			rdata <= next_rdata;
		end
	end

	// ****************************************************************
	// Pin multiplexing
	// ****************************************************************
	logic [7:0] mdir [`PORT_COUNT];
	logic [7:0] mout [`PORT_COUNT];

	// Module-side direction and value per port.  Port 3 is index 0.
	always_comb begin
		// Port 3 fixed module directions and values.
		mdir[0] = 8'h50;
		mout[0] = {3'h0, mod_out.serial_txd, 4'h0};
		// Clock pin: driven only by a synchronous master.
		if (mode.sync && mode.master) begin
			mdir[0][3] = 1'b1;
			mout[0][3] = mod_out.serial_clk_out;
		end else begin
			mdir[0][3] = 1'b0;
		end
		// Port 4 keeps its own direction; only 0-2 carry timer outputs.
		mdir[1] = ctl[1].dir;
		mout[1] = {5'h00, mod_out.timer_cmp};
		// Port 5 clocks out on 4-6, bit 7 and bit 0 inputs.
		mdir[2] = 8'h7E;
		mout[2] = {1'b0, mod_out.aux_clk, mod_out.sub_main_clock,
			mod_out.main_clk, 4'h0};
		// Port 6 has no module; direction stays with software.
		mdir[3] = ctl[3].dir;
		mout[3] = 8'h00;
	end

	// High-impedance control comes from port 5 bit 7 under module use.
	assign hiz_ctl = ctl[2].sel[7] && pin_in[23];

	// Final drive: select bit chooses module or plain I/O per pin.
	always_comb begin
		for (int p = 0; p < `PORT_COUNT; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (ctl[p].sel[b]) begin
					pin_drive[p].oe[b] = mdir[p][b];
					pin_drive[p].o[b]  = mout[p][b];
				end else begin
					pin_drive[p].oe[b] = ctl[p].dir[b];
					pin_drive[p].o[b]  = ctl[p].out[b];
				end
			end
		end
		// Timer high-impedance floats port 4 pins 0 to 6 in any mode.
		// Software may instead float them through select and direction.
		if (hiz_ctl) begin
			pin_drive[1].oe[6:0] = 7'h00;
		end
	end

	// Module inputs: a level reaches a module only when its pin is handed
	// over, otherwise the module sees an idle low.
	always_comb begin
		mod_in = '0;
		mod_in.serial_slave_transmit_enable =
			ctl[0].sel[0] && pin_in[0];
		mod_in.serial_async_receive_data =
			ctl[0].sel[5] && pin_in[5];
		mod_in.serial_clk_in = ctl[0].sel[3] &&
			!(mode.sync && mode.master) && pin_in[3];
		for (int t = 0; t < 3; t++) begin
			mod_in.timer_cap_a[t] = ctl[1].sel[t] && pin_in[8 + t];
			mod_in.timer_cap_b[t] = ctl[1].sel[t] && pin_in[8 + t];
		end
		mod_in.timer_output_high_impedance_ctl = hiz_ctl;
	end

	// Port 6 input path: the direction bit parks the input buffer, but a
	// read of the input register returns the pad level pin_in for every pin.
	logic [7:0] p6_in_active;
	assign p6_in_active = ~ctl[3].dir;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_reset_inputs: assert property (@(posedge pclk)
		$rose(presetn) |-> (pin_drive[0].oe == 8'h00) &&
		(pin_drive[3].oe == 8'h00))
		else $error("Pins not inputs after reset.");

	a_plain_io_dir: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[3].sel[0] == 1'b0) |-> pin_drive[3].oe[0] == ctl[3].dir[0])
		else $error("Plain pin direction wrong.");

	a_txd_route: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[0].sel[4] |-> pin_drive[0].oe[4] &&
		(pin_drive[0].o[4] == mod_out.serial_txd))
		else $error("Transmit data not routed.");

	a_ste_input: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[0].sel[0] |-> !pin_drive[0].oe[0] && !pin_drive[0].o[0] &&
		(mod_in.serial_slave_transmit_enable == pin_in[0]))
		else $error("Slave enable pin wrong.");

	a_rxd_input: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[0].sel[5] |-> !pin_drive[0].oe[5] &&
		(mod_in.serial_async_receive_data == pin_in[5]))
		else $error("Receive data pin wrong.");

	a_clk_async_in: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[0].sel[3] && !mode.sync) |-> !pin_drive[0].oe[3])
		else $error("Async clock pin driven.");

	a_clk_master: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[0].sel[3] && mode.sync && mode.master) |->
		pin_drive[0].oe[3] && (pin_drive[0].o[3] == mod_out.serial_clk_out))
		else $error("Master clock not driven.");

	a_hiz_float: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[2].sel[7] && pin_in[23]) |-> (pin_drive[1].oe[6:0] == 7'h00))
		else $error("Port 4 not floated.");

	a_p5_clocks: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[2].sel[5] |-> pin_drive[2].oe[5] &&
		(pin_drive[2].o[5] == mod_out.sub_main_clock))
		else $error("Sub-main clock not driven.");

	a_p4_low_out: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[1].sel[4] && !hiz_ctl) |-> !pin_drive[1].o[4] &&
		(pin_drive[1].oe[4] == ctl[1].dir[4]))
		else $error("Port 4 bit 4 wrong.");

	// ****************************************************************
	// Checks on the remaining fixed routes
	// ****************************************************************
	// These cover the pins that the checks above leave open. Each one
	// looks at one representative bit where the rule is the same for
	// its neighbours. That keeps the count small, at the cost of
	// trusting the shared code path for the other bits of the group.
	// Timer pins are only checked with the float control low, because
	// the float control overrides the directions of port 4 bits 0 to 6.

	a_p3_six_low: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[0].sel[6] |-> pin_drive[0].oe[6] && !pin_drive[0].o[6])
		else $error("Port 3 bit 6 not driven low.");

	a_p3_seven_in: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[0].sel[7] |-> !pin_drive[0].oe[7])
		else $error("Port 3 bit 7 not an input.");

	a_clk_slave_in: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[0].sel[3] && mode.sync && !mode.master) |->
		!pin_drive[0].oe[3] && (mod_in.serial_clk_in == pin_in[3]))
		else $error("Slave clock not taken from pin.");

	a_cmp_route: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[1].sel[0] && !hiz_ctl) |->
		(pin_drive[1].oe[0] == ctl[1].dir[0]) &&
		(pin_drive[1].o[0] == mod_out.timer_cmp[0]) &&
		(mod_in.timer_cap_a[0] == pin_in[8]) &&
		(mod_in.timer_cap_b[0] == pin_in[8]))
		else $error("Timer channel 0 route wrong.");

	a_p4_own_dir: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl[1].sel[1] && !hiz_ctl) |->
		(pin_drive[1].oe[1] == ctl[1].dir[1]))
		else $error("Port 4 bit 1 direction wrong.");

	a_p4_top_low: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[1].sel[6] |-> !pin_drive[1].o[6])
		else $error("Port 4 bit 6 not low.");

	a_main_clk_out: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[2].sel[4] |-> pin_drive[2].oe[4] &&
		(pin_drive[2].o[4] == mod_out.main_clk))
		else $error("Main clock not driven.");

	a_aux_clk_out: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[2].sel[6] |-> pin_drive[2].oe[6] &&
		(pin_drive[2].o[6] == mod_out.aux_clk))
		else $error("Auxiliary clock not driven.");

	a_hiz_source: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[2].sel[7] |-> !pin_drive[2].oe[7] &&
		(mod_in.timer_output_high_impedance_ctl == pin_in[23]))
		else $error("Float control source wrong.");

	a_p5_low_out: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[2].sel[1] |-> pin_drive[2].oe[1] && !pin_drive[2].o[1])
		else $error("Port 5 bit 1 not driven low.");

	a_p5_zero_in: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[2].sel[0] |-> !pin_drive[2].oe[0])
		else $error("Port 5 bit 0 not an input.");

	a_p6_own_dir: assert property (@(posedge pclk) disable iff (!presetn)
		ctl[3].sel[2] |-> (pin_drive[3].oe[2] == ctl[3].dir[2]) &&
		!pin_drive[3].o[2])
		else $error("Port 6 bit 2 wrong.");

	// An active input buffer must never share its pin with a driver.
	a_p6_in_park: assert property (@(posedge pclk) disable iff (!presetn)
		(p6_in_active & pin_drive[3].oe) == 8'h00)
		else $error("Port 6 input and driver both on.");

	a_reset_clear: assert property (@(posedge pclk)
		!presetn |-> (ctl[0].sel == 8'h00) && (ctl[1].dir == 8'h00) &&
		(ctl[2].sel == 8'h00) && (ctl[3].dir == 8'h00))
		else $error("Select or direction not cleared.");

endmodule

// ---- verification/onchip_modules.sv ----
// Purpose: Stand-in for the serial unit, timers and clock system.
// Assumes: One clock; outputs change just after a rising edge.
// Notes:   A shift pattern gives every module output fresh values.
`timescale 1ns/1ps
module onchip_modules (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	output port_mux_pkg::module_out_t mod_out
);
	import port_mux_pkg::*;
	logic [7:0] pattern;
	logic [7:0] next_pattern;
	// *****************
	// Pattern source
	// *****************
	// Feedback taps keep the pattern from locking, so stuck routes show.
	always_comb begin
		next_pattern = {pattern[6:0],
			pattern[7] ^ pattern[5] ^ pattern[4] ^ pattern[3]};
	end
	// Registered so the pattern only moves on the rising edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pattern <= 8'hA5;
		else
			pattern <= next_pattern;
	end
	assign mod_out = module_out_t'(pattern);
endmodule

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the port pin function mux.
// Assumes: APB slave answers in the first access cycle or later.
// Notes:   Pins are checked at the falling edge, once they have settled.
`timescale 1ns/1ps
`include "port_mux_defs.svh"
module tb_top;
	import port_mux_pkg::*;
	logic             pclk;
	logic             presetn;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [11:0]      paddr;
	logic [31:0]      pwdata;
	logic             pready;
	logic             pslverr;
	logic [31:0]      prdata;
	logic [31:0]      pin_in;
	pin_drive_t [3:0] pin_drive;
	module_out_t      mod_out;
	module_in_t       mod_in;
	logic [7:0]       sel [4];
	logic [7:0]       dir [4];
	logic [7:0]       out [4];
	logic [1:0]       ser;
	logic [32:0]      rq [$];
	pin_drive_t [3:0] pq [$];
	module_in_t       mq [$];
	event             pin_ev;
	int               error_cnt;
	int               checks;
	int               cyc;
	// *****************
	// Harness
	// *****************
	port_pin_function_mux i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .pin_in(pin_in), .pin_drive(pin_drive),
		.mod_out(mod_out), .mod_in(mod_in));
	onchip_modules i_mods (.pclk(pclk), .presetn(presetn),
		.mod_out(mod_out));
	task automatic report_and_stop();
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic fail(input string s);
		error_cnt++;
		$display("[ERR] %0t %s", $time, s);
	endtask
	task automatic cmp_rd(input logic [32:0] e);
		checks++;
		if ({pslverr, prdata} !== e) fail("read data or error flag");
	endtask
	task automatic cmp_pins(input pin_drive_t [3:0] e, input module_in_t m);
		checks++;
		for (int p = 0; p < 4; p++)
			if (pin_drive[p].oe !== e[p].oe) fail("pin enable");
		for (int p = 0; p < 4; p++)
			if ((pin_drive[p].o & pin_drive[p].oe) !== e[p].o)
				fail("pin level");
		if (mod_in !== m) fail("module input");
	endtask
	// Bus cycles leave one idle cycle so no signal is assigned twice.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cfg(input int p, input logic [7:0] s, d, o);
		logic [11:0] b;
		b = 12'(p) * `PORT_STRIDE;
		sel[p] = s;
		dir[p] = d;
		out[p] = o;
		apb(1'b1, `OFS_P3_SEL + b, {24'h0, s});
		apb(1'b1, `OFS_P3_DIR + b, {24'h0, d});
		apb(1'b1, `OFS_P3_OUT + b, {24'h0, o});
	endtask
	task automatic read_all(input int p);
		logic [11:0] b;
		b = 12'(p) * `PORT_STRIDE;
		rd(`OFS_P3_SEL + b, {25'h0, sel[p]});
		rd(`OFS_P3_DIR + b, {25'h0, dir[p]});
		rd(`OFS_P3_OUT + b, {25'h0, out[p]});
		rd(`OFS_P3_IN + b, {25'h0, pin_in[8*p +: 8]});
		rd(`OFS_SERIAL_CTL, {31'h0, ser});
		rd(`OFS_STATUS, {32'h0, sel[2][7] & pin_in[23]});
		rd(12'h048, {1'b1, 32'h0});
	endtask
	// Expected pins and module inputs, noted for the watcher.
	task automatic push_pins();
		pin_drive_t [3:0] e;
		module_in_t       m;
		logic             hz;
		logic             ms;
		logic [7:0]       s3;
		@(negedge pclk);
		s3 = sel[0];
		hz = sel[2][7] & pin_in[23];
		ms = ser[0] & ser[1];
		e[0].oe = (dir[0] & ~s3) | (s3 & {3'h2, 1'b1, ms, 3'h0});
		e[0].o = (out[0] & ~s3) | (s3 & {3'h0, mod_out.serial_txd,
			ms & mod_out.serial_clk_out, 3'h0});
		e[1].oe = dir[1] & {1'b1, {7{~hz}}};
		e[1].o = (out[1] & ~sel[1]) | (sel[1] & {5'h0, mod_out.timer_cmp});
		e[2].oe = (dir[2] & ~sel[2]) | (sel[2] & 8'h7E);
		e[2].o = (out[2] & ~sel[2]) | (sel[2] & {1'b0, mod_out.aux_clk,
			mod_out.sub_main_clock, mod_out.main_clk, 4'h0});
		e[3].oe = dir[3];
		e[3].o = out[3] & ~sel[3];
		for (int p = 0; p < 4; p++)
			e[p].o = e[p].o & e[p].oe;
		m.serial_slave_transmit_enable = s3[0] & pin_in[0];
		m.serial_async_receive_data = s3[5] & pin_in[5];
		m.serial_clk_in = s3[3] & ~ms & pin_in[3];
		m.timer_cap_a = sel[1][2:0] & pin_in[10:8];
		m.timer_cap_b = sel[1][2:0] & pin_in[10:8];
		m.timer_output_high_impedance_ctl = hz;
		pq.push_back(e);
		mq.push_back(m);
		-> pin_ev;
		@(posedge pclk);
	endtask
	// Watchers: reads at the completing edge, pins on each note.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			cmp_rd(rq.pop_front());
	end
	always @(pin_ev) begin
		cmp_pins(pq.pop_front(), mq.pop_front());
	end
	// Hang guard, well above the cycles the sequence needs.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{pin_in, ser, error_cnt, checks, cyc} = '0;
		for (int p = 0; p < 4; p++)
			{sel[p], dir[p], out[p]} = '0;
		void'($urandom(44));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		push_pins();
		for (int p = 0; p < 4; p++)
			read_all(p);
		cfg(0, 8'h08, 8'h08, 8'h08);
		apb(1'b1, `OFS_P3_IN, 32'hFF);
		apb(1'b1, 12'h048, 32'hFF);
		push_pins();
		read_all(0);
		cfg(1, 8'h00, 8'hFF, 8'h55);
		cfg(2, 8'h80, 8'h00, 8'h00);
		pin_in <= 32'h0080_0000;
		push_pins();
		repeat (30) begin
			ser = 2'($urandom);
			apb(1'b1, `OFS_SERIAL_CTL, {30'h0, ser});
			cfg(0, 8'($urandom) & 8'hF9, 8'($urandom), 8'($urandom));
			cfg(1, 8'($urandom) & 8'h7F, 8'($urandom), 8'($urandom));
			cfg(2, 8'($urandom), 8'($urandom), 8'($urandom));
			cfg(3, 8'($urandom), 8'($urandom), 8'($urandom));
			pin_in <= $urandom;
			push_pins();
			read_all(int'($urandom_range(3)));
		end
		report_and_stop();
	end
endmodule
